// ### axs_pkg.sv
package axs_pkg;
   // Clock and control loop timing
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned LOOP_TIME_NS  = 2000000;
   localparam int unsigned LOOP_CYC      = LOOP_TIME_NS / CLK_PERIOD_NS;

   // Command letters in the host_to_device_block command field
   localparam logic [7:0] CMD_LOAD = 8'h50;
   localparam logic [7:0] CMD_GO   = 8'h47;
   localparam logic [7:0] CMD_HALT = 8'h48;
   localparam logic [7:0] CMD_TUNE = 8'h46;
   localparam logic [7:0] CMD_OPEN = 8'h4F;

   // Byte offsets on the register bus
   localparam logic [7:0] OFS_CMD      = 8'h00;
   localparam logic [7:0] OFS_REQ_POS  = 8'h04;
   localparam logic [7:0] OFS_ACT_POS  = 8'h08;
   localparam logic [7:0] OFS_STATUS   = 8'h0C;
   localparam logic [7:0] OFS_DRIVE    = 8'h10;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
   localparam logic [7:0] OFS_IRQ_EN   = 8'h18;
   localparam logic [7:0] OFS_IRQ_CLR  = 8'h1C;
   localparam logic [1:0] INIT_REGION  = 2'h1;   // 0x40..0x7C holds the axis_init_block

   // Word index inside the axis_init_block
   localparam logic [3:0] IX_DIR     = 4'h0;
   localparam logic [3:0] IX_SCALE   = 4'h1;
   localparam logic [3:0] IX_OFFSET  = 4'h2;
   localparam logic [3:0] IX_HMASK   = 4'h3;
   localparam logic [3:0] IX_MAXERR  = 4'h4;
   localparam logic [3:0] IX_GAIN    = 4'h5;
   localparam logic [3:0] IX_EXT_FF  = 4'h6;
   localparam logic [3:0] IX_RET_FF  = 4'h7;
   localparam logic [3:0] IX_EXT_LIM = 4'h8;
   localparam logic [3:0] IX_RET_LIM = 4'h9;
   localparam logic [3:0] IX_SPEED   = 4'hA;
   localparam logic [3:0] IX_LAST    = 4'hA;

   // Built-in defaults used until the first parameter load
   localparam logic [15:0] DEF_DIR     = 16'h0000;
   localparam logic [15:0] DEF_SCALE   = 16'h8000;
   localparam logic [15:0] DEF_OFFSET  = 16'h0000;
   localparam logic [15:0] DEF_HMASK   = 16'h0000;
   localparam logic [15:0] DEF_MAXERR  = 16'h0100;
   localparam logic [15:0] DEF_GAIN    = 16'h0005;
   localparam logic [15:0] DEF_EXT_FF  = 16'h0064;
   localparam logic [15:0] DEF_RET_FF  = 16'h0064;
   localparam logic [15:0] DEF_EXT_LIM = 16'h7FFF;
   localparam logic [15:0] DEF_RET_LIM = 16'h8000;
   localparam logic [15:0] DEF_SPEED   = 16'h0010;
   localparam logic [15:0] DIR_NEG     = 16'hFFFF;

   // Status word bits
   localparam int unsigned ST_LAG  = 1;
   localparam int unsigned ST_AHEAD_PROFILE_ERROR = 2;
   localparam int unsigned ST_OVD  = 12;

   // Interrupt status bits
   localparam int unsigned IRQ_LOAD = 0;
   localparam int unsigned IRQ_LAG  = 1;
   localparam int unsigned IRQ_AHEAD_PROFILE_ERROR = 2;
   localparam int unsigned IRQ_OVD  = 3;

   // Drive code
   localparam logic [11:0] DRIVE_MID = 12'h800;
   localparam logic [11:0] DRIVE_MAX = 12'hFFF;

   typedef enum logic [1:0] {AXS_HOLD, AXS_MOVE, AXS_OPEN} axs_mode_e;
endpackage

// ### axs_param_mem.sv
`timescale 1ns/1ps
// Shadow copy of the axis_init_block, one write port and two registered read ports
module axs_param_mem (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // Write port
   input  wire logic        we,
   input  wire logic [3:0]  waddr,
   input  wire logic [15:0] wdata,
   // Read ports
   input  wire logic [3:0]  raddr_a,
   output logic      [15:0] rdata_a,
   input  wire logic [3:0]  raddr_b,
   output logic      [15:0] rdata_b
);
   logic [15:0] mem [16];

   // Storage array
   always_ff @(posedge hclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // Registered read data
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_a <= 16'h0000;
         rdata_b <= 16'h0000;
      end else begin
         rdata_a <= mem[raddr_a];
         rdata_b <= mem[raddr_b];
      end
   end
endmodule

// ### axs_pos_calc.sv
`timescale 1ns/1ps
// Converts transducer counts into actual position once per loop tick
module axs_pos_calc (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // Inputs
   input  wire logic        tick,
   input  wire logic [15:0] counts,
   input  wire logic [15:0] scale,
   input  wire logic        dir_neg,
   input  wire logic [15:0] offset,
   // Result
   output logic      [15:0] act_pos,
   output logic             valid
);
   logic [31:0] prod;
   logic [15:0] scaled;

   // Scale of 8000 hex is unity gain
   assign prod   = counts * scale;
   assign scaled = prod[30:15];

   // Sign by direction, then add offset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         act_pos <= 16'h0000;
         valid   <= 1'b0;
      end else begin
         valid <= tick;
         if (tick) begin
            act_pos <= dir_neg ? offset - scaled : offset + scaled;
         end
      end
   end

   chk_pos_offset: assert property (@(posedge hclk) disable iff (!hresetn)
      tick |=> act_pos == ($past(dir_neg) ? $past(offset) - $past(scaled) : $past(offset) + $past(scaled)))
      else $error("actual position not offset scaled counts");
endmodule

// ### axs_axis_top.sv
// The AHB-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module axs_axis_top #(
   parameter int unsigned LOOP_CYCLES = axs_pkg::LOOP_CYC
) (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Transducer and drive
   input  wire logic [15:0] xdcr_counts,
   output logic      [11:0] drive_code,
   // Interrupt
   output logic             irq
);
   import axs_pkg::*;

   logic [17:0] loop_cnt_reg;
   logic        tick_reg;
   logic [15:0] cnt_s1_reg, cnt_s2_reg, cnt_s3_reg, cnt_ok_reg;
   logic        acc, dph_reg, wr_reg, wr_now, rd_now;
   logic [7:0]  addr_reg;
   logic [15:0] mem_rd_a, mem_rd_b;
   logic [7:0]  cmd_reg;
   logic        cmd_pend_reg;
   logic [15:0] req_pos_reg, act_pos, status_reg;
   logic        pos_valid, seeded_reg;
   logic        load_busy_reg, load_wv_reg, load_done;
   logic [3:0]  load_idx_reg, load_wi_reg;
   logic [15:0] dir_reg, scale_reg, offset_reg, hmask_reg, maxerr_reg, gain_reg;
   logic [15:0] ext_ff_reg, ret_ff_reg, ext_lim_reg, ret_lim_reg, speed_reg;
   axs_mode_e   mode_reg;
   logic [15:0] cmd_pos_reg;
   logic        tune_reg;
   logic [3:0]  irq_stat_reg, irq_en_reg, irq_set;
   logic signed [16:0] err, tgt_diff;
   logic signed [31:0] drv_raw;
   logic signed [15:0] tgt;
   logic        extending, sat, lag_now, ahead_profile_error_now, halt_now;
   logic [15:0] st_new;
   logic [11:0] drv_new;

   // Signed clamp of a 32-bit drive value to the 12-bit code range
   function automatic logic [11:0] sat12(input logic signed [31:0] v);
      if (v > $signed({20'h00000, DRIVE_MAX})) sat12 = DRIVE_MAX;
      else if (v < 0)                         sat12 = 12'h000;
      else                                    sat12 = v[11:0];
   endfunction

   // Two-flop synchroniser for the transducer counts; a word is only taken once
   // two synchronised samples agree, so a count caught mid-change is never used
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_s1_reg <= 16'h0000;
         cnt_s2_reg <= 16'h0000;
         cnt_s3_reg <= 16'h0000;
         cnt_ok_reg <= 16'h0000;
      end else begin
         cnt_s1_reg <= xdcr_counts;
         cnt_s2_reg <= cnt_s1_reg;
         cnt_s3_reg <= cnt_s2_reg;
         if (cnt_s2_reg == cnt_s3_reg) cnt_ok_reg <= cnt_s2_reg;
      end
   end

   // Control loop timer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         loop_cnt_reg <= 18'h00000;
         tick_reg     <= 1'b0;
      end else begin
         tick_reg <= (loop_cnt_reg == 18'(LOOP_CYCLES - 1));
         loop_cnt_reg <= (loop_cnt_reg == 18'(LOOP_CYCLES - 1)) ? 18'h00000 : loop_cnt_reg + 18'h00001;
      end
   end

   // Bus phase tracking
   assign acc    = hsel & hready & htrans[1];
   assign wr_now = dph_reg & wr_reg;
   assign rd_now = dph_reg & ~wr_reg & ~hreadyout;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dph_reg   <= 1'b0;
         wr_reg    <= 1'b0;
         addr_reg  <= 8'h00;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         dph_reg <= acc | (dph_reg & ~hreadyout);
         if (acc) begin
            wr_reg   <= hwrite;
            addr_reg <= haddr[7:0];
         end
         if (acc && !hwrite) hreadyout <= 1'b0;
         else                hreadyout <= 1'b1;
      end
   end

   // Read data, one wait state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (rd_now) begin
         if (addr_reg[7:6] == INIT_REGION) hrdata <= {16'h0000, mem_rd_a};
         else begin
            case (addr_reg)
               OFS_CMD:      hrdata <= {24'h000000, cmd_reg};
               OFS_REQ_POS:  hrdata <= {16'h0000, req_pos_reg};
               OFS_ACT_POS:  hrdata <= {16'h0000, act_pos};
               OFS_STATUS:   hrdata <= {16'h0000, status_reg};
               OFS_DRIVE:    hrdata <= {20'h00000, drive_code};
               OFS_IRQ_STAT: hrdata <= {28'h0000000, irq_stat_reg};
               OFS_IRQ_EN:   hrdata <= {28'h0000000, irq_en_reg};
               default:      hrdata <= 32'h00000000;
            endcase
         end
      end
   end

   axs_param_mem u_mem (
      .hclk    (hclk),
      .hresetn (hresetn),
      .we      (wr_now && addr_reg[7:6] == INIT_REGION),
      .waddr   (addr_reg[5:2]),
      .wdata   (hwdata[15:0]),
      .raddr_a (haddr[5:2]),
      .rdata_a (mem_rd_a),
      .raddr_b (load_idx_reg),
      .rdata_b (mem_rd_b)
   );

   // Host command and requested position
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmd_reg      <= 8'h00;
         cmd_pend_reg <= 1'b0;
         req_pos_reg  <= 16'h0000;
         irq_en_reg   <= 4'h0;
      end else begin
         cmd_pend_reg <= wr_now && addr_reg == OFS_CMD;
         if (wr_now && addr_reg == OFS_CMD)     cmd_reg     <= hwdata[7:0];
         if (wr_now && addr_reg == OFS_REQ_POS) req_pos_reg <= hwdata[15:0];
         if (wr_now && addr_reg == OFS_IRQ_EN)  irq_en_reg  <= hwdata[3:0];
      end
   end

   // Parameter load sequencer walks the shadow block
   assign load_done = load_wv_reg && load_wi_reg == IX_LAST;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         load_busy_reg <= 1'b0;
         load_idx_reg  <= 4'h0;
         load_wv_reg   <= 1'b0;
         load_wi_reg   <= 4'h0;
      end else begin
         load_wv_reg <= load_busy_reg;
         load_wi_reg <= load_idx_reg;
         if (cmd_pend_reg && cmd_reg == CMD_LOAD && !load_busy_reg) begin
            load_busy_reg <= 1'b1;
            load_idx_reg  <= 4'h0;
         end else if (load_busy_reg) begin
            if (load_idx_reg == IX_LAST) load_busy_reg <= 1'b0;
            else                         load_idx_reg  <= load_idx_reg + 4'h1;
         end
      end
   end

   // Active parameters: defaults, loaded words, tuned feed forward
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dir_reg     <= DEF_DIR;
         scale_reg   <= DEF_SCALE;
         offset_reg  <= DEF_OFFSET;
         hmask_reg   <= DEF_HMASK;
         maxerr_reg  <= DEF_MAXERR;
         gain_reg    <= DEF_GAIN;
         ext_ff_reg  <= DEF_EXT_FF;
         ret_ff_reg  <= DEF_RET_FF;
         ext_lim_reg <= DEF_EXT_LIM;
         ret_lim_reg <= DEF_RET_LIM;
         speed_reg   <= DEF_SPEED;
      end else if (load_wv_reg) begin
         case (load_wi_reg)
            IX_DIR:     dir_reg     <= mem_rd_b;
            IX_SCALE:   scale_reg   <= mem_rd_b;
            IX_OFFSET:  offset_reg  <= mem_rd_b;
            IX_HMASK:   hmask_reg   <= mem_rd_b;
            IX_MAXERR:  maxerr_reg  <= mem_rd_b;
            IX_GAIN:    gain_reg    <= mem_rd_b;
            IX_EXT_FF:  ext_ff_reg  <= mem_rd_b;
            IX_RET_FF:  ret_ff_reg  <= mem_rd_b;
            IX_EXT_LIM: ext_lim_reg <= mem_rd_b;
            IX_RET_LIM: ret_lim_reg <= mem_rd_b;
            IX_SPEED:   speed_reg   <= mem_rd_b;
            default: ;
         endcase
      end else if (pos_valid && tune_reg && mode_reg == AXS_MOVE) begin
         // Behind the profile wants more feed forward, ahead wants less
         if (extending) begin
            if (lag_now)       ext_ff_reg <= ext_ff_reg + 16'h0001;
            else if (ahead_profile_error_now) ext_ff_reg <= ext_ff_reg - 16'h0001;
         end else begin
            if (lag_now)       ret_ff_reg <= ret_ff_reg + 16'h0001;
            else if (ahead_profile_error_now) ret_ff_reg <= ret_ff_reg - 16'h0001;
         end
      end
   end

   axs_pos_calc u_pos (
      .hclk    (hclk),
      .hresetn (hresetn),
      .tick    (tick_reg),
      .counts  (cnt_ok_reg),
      .scale   (scale_reg),
      .dir_neg (dir_reg == DIR_NEG),
      .offset  (offset_reg),
      .act_pos (act_pos),
      .valid   (pos_valid)
   );

   // Servo arithmetic for the control step
   always_comb begin
      tgt = $signed(req_pos_reg);
      if ($signed(tgt) > $signed(ext_lim_reg)) tgt = $signed(ext_lim_reg);
      if ($signed(tgt) < $signed(ret_lim_reg)) tgt = $signed(ret_lim_reg);
      tgt_diff  = 17'(tgt) - 17'($signed(cmd_pos_reg));
      extending = tgt_diff > 0;
      err       = 17'($signed(cmd_pos_reg)) - 17'($signed(act_pos));
      if (mode_reg == AXS_OPEN)
         drv_raw = 32'($signed({1'b0, DRIVE_MID})) + 32'($signed(req_pos_reg));
      else begin
         drv_raw = 32'($signed({1'b0, DRIVE_MID})) + 32'(err) * 32'($signed({1'b0, gain_reg}));
         if (mode_reg == AXS_MOVE)
            drv_raw = extending ? drv_raw + 32'($signed({1'b0, ext_ff_reg}))
                                : drv_raw - 32'($signed({1'b0, ret_ff_reg}));
      end
      drv_new  = sat12(drv_raw);
      sat      = drv_raw > $signed({20'h00000, DRIVE_MAX}) || drv_raw < 0;
      lag_now  = mode_reg == AXS_MOVE && (extending ? err > 17'($signed({1'b0, maxerr_reg}))
                                                    : err < -17'($signed({1'b0, maxerr_reg})));
      ahead_profile_error_now = mode_reg == AXS_MOVE && (extending ? err < -17'($signed({1'b0, maxerr_reg}))
                                                    : err > 17'($signed({1'b0, maxerr_reg})));
      st_new = 16'h0000;
      st_new[ST_OVD]  = sat;
      st_new[ST_LAG]  = lag_now;
      st_new[ST_AHEAD_PROFILE_ERROR] = ahead_profile_error_now;
      halt_now = |(st_new & ~hmask_reg);
   end

   // Axis mode and profile position
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_reg    <= AXS_HOLD;
         cmd_pos_reg <= 16'h0000;
         tune_reg    <= 1'b0;
         seeded_reg  <= 1'b0;
      end else if (load_done) begin
         mode_reg    <= AXS_HOLD;
         cmd_pos_reg <= act_pos;
         seeded_reg  <= 1'b0;
      end else if (cmd_pend_reg && cmd_reg == CMD_GO) begin
         mode_reg <= AXS_MOVE;
      end else if (cmd_pend_reg && cmd_reg == CMD_HALT) begin
         mode_reg    <= AXS_HOLD;
         cmd_pos_reg <= (mode_reg == AXS_OPEN) ? act_pos : cmd_pos_reg;
      end else if (cmd_pend_reg && cmd_reg == CMD_OPEN) begin
         mode_reg <= AXS_OPEN;
      end else if (cmd_pend_reg && cmd_reg == CMD_TUNE) begin
         tune_reg <= 1'b1;
      end else if (load_busy_reg) begin
         // Positions from a half-loaded block are not trusted; reseed after the load
         seeded_reg <= 1'b0;
      end else if (pos_valid) begin
         seeded_reg <= 1'b1;
         if (!seeded_reg) cmd_pos_reg <= act_pos;
         else if (halt_now) begin
            mode_reg    <= AXS_HOLD;
            cmd_pos_reg <= act_pos;
            tune_reg    <= 1'b0;
         end else begin
            case (mode_reg)
               AXS_MOVE: begin
                  if (tgt_diff > 17'($signed({1'b0, speed_reg})))
                     cmd_pos_reg <= cmd_pos_reg + speed_reg;
                  else if (tgt_diff < -17'($signed({1'b0, speed_reg})))
                     cmd_pos_reg <= cmd_pos_reg - speed_reg;
                  else begin
                     cmd_pos_reg <= tgt;
                     mode_reg    <= AXS_HOLD;
                     tune_reg    <= 1'b0;
                  end
               end
               AXS_OPEN: cmd_pos_reg <= act_pos;
               AXS_HOLD: ;
               default:  mode_reg <= AXS_HOLD;
            endcase
         end
      end
   end

   // Status word and drive output
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status_reg <= 16'h0000;
         drive_code <= DRIVE_MID;
      end else begin
         // Cleared by load end or go; a new error in the same cycle still lands
         status_reg <= ((load_done || (cmd_pend_reg && cmd_reg == CMD_GO)) ? 16'h0000 : status_reg)
                       | ((pos_valid && seeded_reg) ? st_new : 16'h0000);
         if (pos_valid) drive_code <= seeded_reg ? drv_new : DRIVE_MID;
      end
   end

   // Interrupt status, set wins over clear
   always_comb begin
      irq_set = 4'h0;
      irq_set[IRQ_LOAD] = load_done;
      irq_set[IRQ_LAG]  = pos_valid && seeded_reg && lag_now;
      irq_set[IRQ_AHEAD_PROFILE_ERROR] = pos_valid && seeded_reg && ahead_profile_error_now;
      irq_set[IRQ_OVD]  = pos_valid && seeded_reg && sat;
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_stat_reg <= 4'h0;
         irq          <= 1'b0;
      end else begin
         irq_stat_reg <= (irq_stat_reg & ~((wr_now && addr_reg == OFS_IRQ_CLR) ? hwdata[3:0] : 4'h0)) | irq_set;
         irq          <= |(irq_stat_reg & irq_en_reg);
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_load_req;
      cmd_pend_reg && cmd_reg == CMD_LOAD && !load_busy_reg;
   endsequence
   sequence s_load_walk;
      load_busy_reg ##10 load_busy_reg ##1 (!load_busy_reg && load_done);
   endsequence

   chk_load_cmd_code:  assert property (s_load_req |=> s_load_walk)
      else $error("load command did not walk all words");
   chk_load_steady:    assert property (load_busy_reg && load_idx_reg != IX_LAST
                                        |=> load_busy_reg && load_idx_reg == $past(load_idx_reg) + 4'h1)
      else $error("load walk skipped or stopped early");
   chk_params_kept:    assert property (!load_wv_reg |=> $stable(scale_reg) && $stable(hmask_reg))
      else $error("parameter changed without load");
   chk_open_drive:     assert property (pos_valid && seeded_reg && mode_reg == AXS_OPEN && !sat
                                        |=> drive_code == 12'(32'(DRIVE_MID) + 32'($signed($past(req_pos_reg)))))
      else $error("open loop drive not centred on mid code");
   chk_ovd_halt:       assert property (pos_valid && seeded_reg && sat && !hmask_reg[ST_OVD] && !load_done
                                        && !cmd_pend_reg && !load_busy_reg
                                        |=> mode_reg == AXS_HOLD && status_reg[ST_OVD])
      else $error("overdrive did not halt axis");
   chk_mask_blocks:    assert property (pos_valid && seeded_reg && mode_reg == AXS_MOVE && lag_now && !sat
                                        && hmask_reg[ST_LAG] && !cmd_pend_reg && !load_done |=> mode_reg != AXS_HOLD
                                        || ($past(tgt_diff) <= 17'($signed({1'b0, $past(speed_reg)}))
                                            && $past(tgt_diff) >= -17'($signed({1'b0, $past(speed_reg)}))))
      else $error("masked error halted axis");
   chk_tune_ff:        assert property (pos_valid && tune_reg && mode_reg == AXS_MOVE && !extending && lag_now
                                        && !load_wv_reg |=> ret_ff_reg == $past(ret_ff_reg) + 16'h0001)
      else $error("tune did not raise retract feed forward");
   chk_go_moves:       assert property (cmd_pend_reg && cmd_reg == CMD_GO && !load_done |=> mode_reg == AXS_MOVE)
      else $error("go command did not start move");
   chk_loop_period:    assert property (tick_reg |=> !tick_reg [*8])
      else $error("loop tick repeated too soon");
   chk_status_prompt:  assert property (pos_valid && seeded_reg && (lag_now || ahead_profile_error_now) && !load_done
                                        && !cmd_pend_reg |=> status_reg[ST_LAG] || status_reg[ST_AHEAD_PROFILE_ERROR])
      else $error("error not reported in status word");
endmodule

// ### axs_axis_model.sv
`timescale 1ns/1ps
// Transducer on a stalled axis: counts follow where the bench places it
module axs_axis_model (
   // Clock
   input  wire logic        hclk,
   // Axis placement
   input  wire logic [15:0] start_pos,
   // Transducer
   output logic      [15:0] xdcr_counts
);
   // Axis never moves under drive, so a go builds following error
   always_ff @(posedge hclk) begin
      xdcr_counts <= start_pos;
   end
endmodule

// ### axs_axis_top_tb_top.sv
`timescale 1ns/1ps
// Bench: AHB-Lite master tasks and scenario sequence
module axs_axis_top_tb_top;
   import axs_pkg::*;
   localparam int unsigned LC = 50;
   logic        hclk;
   logic        hresetn;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic [15:0] xdcr_counts;
   logic [15:0] start_pos;
   logic [11:0] drive_code;
   logic        irq;
   logic [31:0] rd;
   logic [15:0] oreq [2] = '{16'h0064, 16'hFF9C};
   logic [11:0] oexp [2] = '{12'h864, 12'h79C};
   logic [15:0] pinit [11] = '{16'hFFFF, 16'h4000, 16'h0064, 16'hEFFF, 16'h0100, 16'h0005,
                               16'h0064, 16'h0064, 16'hFC00, 16'h8000, 16'h0010};
   int          fails;
   int          total_checks;

   axs_axis_top #(.LOOP_CYCLES(LC)) uut (
      .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .xdcr_counts(xdcr_counts), .drive_code(drive_code),
      .irq(irq));
   axs_axis_model axis (.hclk(hclk), .start_pos(start_pos), .xdcr_counts(xdcr_counts));

   // Clock
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   // One single word transfer; read data lands in rd
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      haddr  <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   // Compare and count
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", n, exp, seen);
      end
   endtask

   // Control loop ticks
   task automatic wait_loops(input int n);
      repeat (n * LC + 4) @(posedge hclk);
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Watchdog, far beyond the few thousand cycles the scenarios need
   initial begin
      #200000;
      fails++;
      conclude;
   end

   // Scenarios
   initial begin
      hresetn = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      start_pos = 16'h03E8;
      fails = 0;
      total_checks = 0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      chk("reset drive", {20'h0, drive_code}, 32'h800);
      xfer(1'b0, OFS_DRIVE, 32'h0);
      chk("default drive", rd, {20'h0, DRIVE_MID});
      chk("okay resp", {31'h0, hresp}, 32'h0);
      xfer(1'b0, 8'h30, 32'h0);
      chk("unmapped", rd, 32'h0);
      wait_loops(2);
      xfer(1'b0, OFS_ACT_POS, 32'h0);
      chk("act pos", rd, 32'h3E8);
      // Stage every word: reversed, half scale, offset 100, extend limit below axis, overdrive-only halt
      for (int i = 0; i < 11; i++) begin
         xfer(1'b1, 8'h40 + 8'(4 * i), {16'h0, pinit[i]});
      end
      wait_loops(2);
      xfer(1'b0, OFS_ACT_POS, 32'h0);
      chk("staged act", rd, 32'h3E8);
      xfer(1'b1, OFS_CMD, {24'h0, CMD_LOAD});
      wait_loops(2);
      xfer(1'b0, OFS_ACT_POS, 32'h0);
      chk("loaded act", rd, 32'hFE70);
      xfer(1'b0, OFS_IRQ_STAT, 32'h0);
      chk("load done", rd, 32'h1);
      chk("irq off", {31'h0, irq}, 32'h0);
      xfer(1'b1, OFS_IRQ_EN, 32'h1);
      repeat (3) @(posedge hclk);
      chk("irq on", {31'h0, irq}, 32'h1);
      xfer(1'b1, OFS_IRQ_CLR, 32'h1);
      repeat (3) @(posedge hclk);
      chk("irq clr", {31'h0, irq}, 32'h0);
      // Open loop both ways, extend limit already passed
      for (int i = 0; i < 2; i++) begin
         xfer(1'b1, OFS_REQ_POS, {16'h0, oreq[i]});
         xfer(1'b1, OFS_CMD, {24'h0, CMD_OPEN});
         wait_loops(2);
         chk("open drive", {20'h0, drive_code}, {20'h0, oexp[i]});
      end
      xfer(1'b1, OFS_CMD, {24'h0, CMD_HALT});
      wait_loops(2);
      chk("halt drive", {20'h0, drive_code}, 32'h800);
      // Go with auto-tune on a stalled axis until overdrive
      xfer(1'b1, OFS_REQ_POS, 32'hF448);
      xfer(1'b1, OFS_CMD, {24'h0, CMD_GO});
      xfer(1'b1, OFS_CMD, {24'h0, CMD_TUNE});
      rd = 32'h0;
      for (int i = 0; i < 60 && rd[12] !== 1'b1; i++) begin
         wait_loops(1);
         xfer(1'b0, OFS_STATUS, 32'h0);
      end
      chk("status", rd & 32'h1006, 32'h1002);
      xfer(1'b0, OFS_IRQ_STAT, 32'h0);
      chk("err irq", rd, 32'hA);
      chk("irq masked", {31'h0, irq}, 32'h0);
      wait_loops(2);
      chk("ovd halt", {20'h0, drive_code}, 32'h800);
      conclude;
   end
endmodule
